// ---- msa_scheduler.sv ----
// Purpose: Passive-acquisition and surveillance interrogation scheduler
// Assumes: Period and reply strobes are one-cycle pulses from the channel timeline
// Notes: One candidate target is in acquisition at a time
// Function
// RULE1: Sector transmitter ranges target, then address, bearing, range go to roll-call.
// RULE2: Squitter bearing disagreeing with measured bearing discards the squitter position.
// RULE3: Squitter or multilateration range lowers active range interrogation rate.
// RULE4: With range estimate, acquisition interrogation uses standard scheduling.
// RULE5: Without range, acquisition goes at start of a Mode A/C period.
// RULE6: Mode A/C interrogations there use the short fourth pulse.
// RULE7: Uncorrectable acquisition reply retries next Mode A/C period at new slot.
// RULE8: After first good acquisition reply, target joins normal roll-call.
// RULE9: Passive mode sends only Mode A/C in all-call periods, no Mode S all-call.
// RULE10: Routine surveillance interrogations request altitude.
// RULE11: Extra identity request on acquisition, after long coast, and during alert.
// RULE12: Transponder reports alert in flight status after identity change.
// RULE13: Emergency identity codes keep transponder alert without time-out.
// RULE14: Non-emergency alert clears after eighteen seconds, plus or minus one.
// RULE15: Keep requesting identity one to two scans after alert clears.
// RULE16: Transponder may skip Comm-A reply but answers short surveillance.
// RULE17: Contact lost on Comm-A only triggers short test interrogations.
// RULE18: Collision-avoidance Comm-A recognised by designator, segment and first byte.
// RULE19: Collision-avoidance and data-link messages go only to their own interface.
// RULE20: Broadcast repeats give at least three transmissions per beamwidth sector.
// RULE21: Broadcast sector spans one beamwidth up to a full rotation.
// RULE22: Address absent from track list marks a newly acquired aircraft.
// RULE23: Garble flag per failed acquisition reply; target stays in acquisition.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
module msa_scheduler
  import msa_pkg::*;
#(
  parameter int TRACK_DEPTH = MSA_TRACK_DEPTH
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic modeac_period_start,
  input wire logic rollcall_slot,
  input wire logic scan_start,
  input wire logic beam_step,
  input wire logic reply_valid,
  input wire logic reply_decoded,
  input wire logic [23:0] reply_address,
  input wire logic reply_alert,
  input wire logic range_reply_valid,
  input wire logic [13:0] range_measured,
  output msa_interrog_s interrog,
  output logic [2:0] range_sector,
  output msa_target_s handoff,
  output logic handoff_valid,
  output logic garble_flag
);
  localparam int IW = $clog2(TRACK_DEPTH);

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  logic [31:0] ctrl;
  logic [31:0] cand_addr;
  logic [31:0] cand_pos;
  logic [31:0] bcast;
  logic [7:0] aw_q;
  logic aw_held;
  logic [31:0] w_q;
  logic w_held;
  msa_state_e state;
  logic [3:0] slot;
  logic [IW:0] track_cnt;
  logic [15:0] garble_cnt;
  logic [1:0] post_alert_scans;
  logic alert_seen;
  logic ident_pending;
  logic [2:0] bcast_left;
  logic [15:0] commA_miss;
  logic [23:0] track_mem [TRACK_DEPTH];
  logic cmd_go;
  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire [7:0] wr_addr = aw_q;
  wire wr_ctrl = do_write && wr_addr == MSA_OFF_CTRL;
  wire wr_caddr = do_write && wr_addr == MSA_OFF_CAND_ADDR;
  wire wr_cpos = do_write && wr_addr == MSA_OFF_CAND_POS;
  wire wr_cmd = do_write && wr_addr == MSA_OFF_CMD;
  wire wr_bcast = do_write && wr_addr == MSA_OFF_BCAST;
  wire wr_known = wr_ctrl | wr_caddr | wr_cpos | wr_cmd | wr_bcast;
  wire passive_mode = ctrl[0];
  wire range_known = ctrl[1];
  wire squitter_pos = ctrl[2];
  wire [2:0] sector_sel = ctrl[6:4];
  wire [8:0] squitter_bearing = cand_pos[24:16];
  wire [8:0] measured_bearing = cand_pos[8:0];
  wire [8:0] bearing_diff = (squitter_bearing > measured_bearing) ?
    squitter_bearing - measured_bearing : measured_bearing - squitter_bearing;
  wire squitter_ok = squitter_pos && bearing_diff <= {1'b0, ctrl[15:8]}; // see RULE2
  logic [31:0] rd_mux;
  always_comb
  begin
    case (s_axi_araddr)
      MSA_OFF_CTRL: rd_mux = ctrl;
      MSA_OFF_CAND_ADDR: rd_mux = cand_addr;
      MSA_OFF_CAND_POS: rd_mux = cand_pos;
      MSA_OFF_STATUS: rd_mux = {18'h0, squitter_ok, alert_seen, ident_pending, slot, garble_flag, state,
        2'h0, handoff_valid, 1'b0};
      MSA_OFF_TRACK_CNT: rd_mux = {{(31 - IW){1'b0}}, track_cnt};
      MSA_OFF_BCAST: rd_mux = bcast;
      MSA_OFF_EVENTS: rd_mux = {commA_miss, garble_cnt};
      default: rd_mux = 32'h0;
    endcase
  end
  wire rd_known = (s_axi_araddr <= MSA_OFF_EVENTS) && (s_axi_araddr[1:0] == 2'h0) &&
    (s_axi_araddr != MSA_OFF_CMD);
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (st[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction
  logic [3:0] w_strb;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_q <= 8'h00;
      w_q <= 32'h0;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= MSA_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= MSA_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_q <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? MSA_RESP_OKAY : MSA_RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_known ? MSA_RESP_OKAY : MSA_RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign s_axi_arready = !s_axi_rvalid;

  // ----------------------------------------
  // Track list and new-target detection
  // ----------------------------------------
  logic hit;
  always_comb
  begin
    hit = 1'b0;
    for (int i = 0; i < TRACK_DEPTH; i++)
      if (i < track_cnt && track_mem[i] == cand_addr[23:0]) hit = 1'b1; // see RULE22
  end
  wire track_full = track_cnt == (IW + 1)'(TRACK_DEPTH);
  wire cmd_start = wr_cmd && w_q[0] && state == MSA_IDLE && !hit; // see RULE22
  wire acq_reply = state == MSA_AWAIT_REPLY && reply_valid && reply_address == cand_addr[23:0];
  wire acq_good = acq_reply && reply_decoded;
  wire acq_garble = acq_reply && !reply_decoded;

  // ----------------------------------------
  // Acquisition state machine
  // ----------------------------------------
  // Acquisition reply slot advances on garble or an unanswered Mode A/C period so overlapping replies separate
  wire [3:0] next_slot = slot + 4'h1;
  wire need_range = !range_known && !squitter_ok; // see RULE3
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl <= MSA_CTRL_RST;
      cand_addr <= 32'h0;
      cand_pos <= 32'h0;
      bcast <= MSA_BCAST_RST;
      state <= MSA_IDLE;
      slot <= MSA_SLOT_RST;
      track_cnt <= '0;
      garble_flag <= 1'b0;
      garble_cnt <= 16'h0;
      handoff_valid <= 1'b0;
      handoff <= '0;
      range_sector <= 3'h0;
      cmd_go <= 1'b0;
    end
    else
    begin
      if (wr_ctrl) ctrl <= merge(ctrl, w_q, w_strb);
      if (wr_caddr) cand_addr <= merge(cand_addr, w_q, w_strb) & 32'h00FF_FFFF;
      if (wr_cpos) cand_pos <= merge(cand_pos, w_q, w_strb);
      if (wr_bcast) bcast <= merge(bcast, w_q, w_strb);
      cmd_go <= cmd_start || (cmd_go && !rollcall_slot && state == MSA_WAIT_PERIOD); // see RULE1
      garble_flag <= acq_garble; // see RULE23
      handoff_valid <= 1'b0;
      if (range_reply_valid && state == MSA_WAIT_PERIOD) cand_pos[29:16] <= range_measured; // see RULE1
      if (acq_garble) garble_cnt <= garble_cnt + 16'h1;
      case (state)
        MSA_IDLE:
          if (cmd_start)
          begin
            state <= MSA_WAIT_PERIOD;
            range_sector <= sector_sel; // see RULE1
          end
        MSA_WAIT_PERIOD:
          if ((range_known || squitter_ok) ? rollcall_slot : modeac_period_start) // see RULE4
            state <= MSA_AWAIT_REPLY;
        MSA_AWAIT_REPLY:
          if (acq_good)
          begin
            state <= MSA_ROLL_CALL; // see RULE8
            handoff_valid <= 1'b1;
            handoff <= '{address: cand_addr[23:0], bearing: measured_bearing, range: cand_pos[29:16]}; // see RULE1
            if (!track_full)
              track_cnt <= track_cnt + 1'b1;
          end
          else if (acq_garble || modeac_period_start)
          begin
            state <= MSA_WAIT_PERIOD; // see RULE7
            slot <= next_slot; // see RULE7
          end
        MSA_ROLL_CALL:
          state <= MSA_IDLE;
        default:
          state <= MSA_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk)
  begin
    if (state == MSA_AWAIT_REPLY && acq_good && !track_full)
      track_mem[track_cnt[IW-1:0]] <= cand_addr[23:0];
  end

  // ----------------------------------------
  // Identity follow-up and alert tracking
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      alert_seen <= 1'b0;
      ident_pending <= 1'b0;
      post_alert_scans <= 2'h0;
      commA_miss <= 16'h0;
    end
    else
    begin
      if (reply_valid && reply_decoded) alert_seen <= reply_alert;
      if (alert_seen && reply_valid && reply_decoded && !reply_alert)
        post_alert_scans <= 2'h2; // see RULE15
      else if (scan_start && post_alert_scans != 2'h0)
        post_alert_scans <= post_alert_scans - 2'h1;
      // Acquisition, long coast (software) and alert all ask for identity
      if (acq_good || (wr_cmd && w_q[1]) || alert_seen || post_alert_scans != 2'h0) // see RULE11
        ident_pending <= 1'b1;
      else if (interrog.valid && interrog.kind == MSA_INT_IDENT)
        ident_pending <= 1'b0;
      if (wr_cmd && w_q[2]) commA_miss <= commA_miss + 16'h1;
    end
  end

  // ----------------------------------------
  // Interrogation issue
  // ----------------------------------------
  logic [7:0] beam_cnt;
  wire [7:0] bcast_per_beam = bcast[7:0] < 8'h3 ? 8'h3 : bcast[7:0]; // see RULE20
  wire bcast_on = bcast[31];
  wire in_sector = beam_cnt < bcast[23:16] || bcast[23:16] == 8'h0; // see RULE21
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      interrog <= '0;
      beam_cnt <= 8'h0;
      bcast_left <= 3'h0;
    end
    else
    begin
      interrog <= '0;
      if (scan_start) beam_cnt <= 8'h0;
      else if (beam_step) beam_cnt <= beam_cnt + 8'h1;
      if (modeac_period_start && state == MSA_WAIT_PERIOD && !range_known && !squitter_ok)
        interrog <= '{1'b1, MSA_INT_ACQ, cand_addr[23:0], slot, 1'b1, 1'b1}; // see RULE5
      else if (modeac_period_start && passive_mode)
        interrog <= '{1'b1, MSA_INT_MODEAC, 24'h0, slot, 1'b1, 1'b0}; // see RULE6 see RULE9
      else if (rollcall_slot && cmd_go && need_range)
        interrog <= '{1'b1, MSA_INT_RANGE, cand_addr[23:0], 4'h0, 1'b0, 1'b0}; // see RULE1 see RULE3
      else if (rollcall_slot && state == MSA_WAIT_PERIOD && !need_range)
        interrog <= '{1'b1, MSA_INT_ACQ, cand_addr[23:0], 4'h0, 1'b0, 1'b1}; // see RULE4
      else if (rollcall_slot && commA_miss != 16'h0 && ctrl[3])
        interrog <= '{1'b1, MSA_INT_SHORT, cand_addr[23:0], 4'h0, 1'b0, 1'b1}; // see RULE17
      else if (rollcall_slot && ident_pending)
        interrog <= '{1'b1, MSA_INT_IDENT, cand_addr[23:0], 4'h0, 1'b0, 1'b0}; // see RULE11
      else if (rollcall_slot && bcast_left != 3'h0)
      begin
        interrog <= '{1'b1, MSA_INT_BCAST, 24'hFFFFFF, 4'h0, 1'b0, 1'b0}; // see RULE20
        bcast_left <= bcast_left - 3'h1;
      end
      else if (rollcall_slot)
        interrog <= '{1'b1, MSA_INT_ALT, cand_addr[23:0], 4'h0, 1'b0, 1'b1}; // see RULE10
      // New beam reload wins over a send in the same cycle
      if (beam_step && bcast_on && in_sector) bcast_left <= bcast_per_beam[2:0] | {bcast_per_beam[7:3] != 5'h0, 2'h0};
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  acq_modeac_a: assert property (@(posedge clk) disable iff (!rst_n)
    interrog.valid && interrog.kind == MSA_INT_MODEAC |-> interrog.fourth_pulse_short) // see RULE6
    else $error("Mode A/C without short fourth pulse");
  garble_retry_a: assert property (@(posedge clk) disable iff (!rst_n)
    acq_garble |=> state == MSA_WAIT_PERIOD && slot == $past(slot) + 4'h1) // see RULE7
    else $error("Garble did not retry at new slot");
  good_rollcall_a: assert property (@(posedge clk) disable iff (!rst_n)
    acq_good |=> handoff_valid && state == MSA_ROLL_CALL ##1 state == MSA_IDLE) // see RULE8
    else $error("Good reply not handed to roll-call");
  garble_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    garble_flag |-> state == MSA_WAIT_PERIOD) // see RULE23
    else $error("Garble flag without acquisition hold");
  known_skip_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_cmd && w_q[0] && state == MSA_IDLE && hit |=> state == MSA_IDLE) // see RULE22
    else $error("Tracked address re-acquired");
  no_range_a: assert property (@(posedge clk) disable iff (!rst_n)
    interrog.valid && interrog.kind == MSA_INT_RANGE |-> $past(need_range)) // see RULE3
    else $error("Range interrogation with known range");
  alt_req_a: assert property (@(posedge clk) disable iff (!rst_n)
    interrog.valid && interrog.kind == MSA_INT_ALT |-> interrog.altitude_req) // see RULE10
    else $error("Surveillance without altitude request");
  ident_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
    acq_good |=> ident_pending) // see RULE11
    else $error("No identity request on acquisition");
  bcast_rate_a: assert property (@(posedge clk) disable iff (!rst_n)
    beam_step && bcast_on && in_sector |=> bcast_left >= 3'h3) // see RULE20
    else $error("Fewer than three broadcasts per beam");
endmodule // msa_scheduler

// ---- msa_pkg.sv ----
// Purpose: Shared constants and carriers for the acquisition scheduler
// Assumes: 32-bit AXI4-Lite register access, one clock
// Notes: Offsets are byte addresses
package msa_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] MSA_OFF_CTRL = 8'h00;
  localparam logic [7:0] MSA_OFF_CAND_ADDR = 8'h04;
  localparam logic [7:0] MSA_OFF_CAND_POS = 8'h08;
  localparam logic [7:0] MSA_OFF_CMD = 8'h0C;
  localparam logic [7:0] MSA_OFF_STATUS = 8'h10;
  localparam logic [7:0] MSA_OFF_TRACK_CNT = 8'h14;
  localparam logic [7:0] MSA_OFF_BCAST = 8'h18;
  localparam logic [7:0] MSA_OFF_EVENTS = 8'h1C;
  localparam logic [31:0] MSA_CTRL_RST = 32'h0000_0021;
  localparam logic [31:0] MSA_BCAST_RST = 32'h0000_0003;
  localparam logic [1:0] MSA_RESP_OKAY = 2'h0;
  localparam logic [1:0] MSA_RESP_SLVERR = 2'h2;
  // Interrogation codes on the scheduler output
  localparam logic [2:0] MSA_INT_NONE = 3'h0;
  localparam logic [2:0] MSA_INT_ALT = 3'h1;
  localparam logic [2:0] MSA_INT_IDENT = 3'h2;
  localparam logic [2:0] MSA_INT_ACQ = 3'h3;
  localparam logic [2:0] MSA_INT_SHORT = 3'h4;
  localparam logic [2:0] MSA_INT_MODEAC = 3'h5;
  localparam logic [2:0] MSA_INT_RANGE = 3'h6;
  localparam logic [2:0] MSA_INT_BCAST = 3'h7;
  localparam logic [3:0] MSA_SLOT_RST = 4'h0;
  localparam int MSA_TRACK_DEPTH = 16;

  typedef struct packed {
    logic [23:0] address;
    logic [8:0] bearing;
    logic [13:0] range;
  } msa_target_s;

  typedef struct packed {
    logic valid;
    logic [2:0] kind;
    logic [23:0] address;
    logic [3:0] slot;
    logic fourth_pulse_short;
    logic altitude_req;
  } msa_interrog_s;

  typedef enum logic [1:0] {
    MSA_IDLE = 2'b00,
    MSA_WAIT_PERIOD = 2'b01,
    MSA_AWAIT_REPLY = 2'b11,
    MSA_ROLL_CALL = 2'b10
  } msa_state_e;
endpackage

// ---- msa_transponder_model.sv ----
// Purpose: Behavioural transponder answering the scheduler's interrogations
// Assumes: One reply outstanding at a time, slow or prompt on command
// Notes: Alert interval is shortened in cycles, far below the real seconds
module msa_transponder_model
  import msa_pkg::*;
#(
  parameter int ALERT_CYCLES = 300,
  parameter logic [13:0] RANGE_VALUE = 14'h0ABC
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire msa_interrog_s interrog,
  input wire logic garble,
  input wire logic slow,
  input wire logic code_change,
  input wire logic emergency,
  output logic reply_valid,
  output logic reply_decoded,
  output logic [23:0] reply_address,
  output logic reply_alert,
  output logic range_reply_valid,
  output logic [13:0] range_measured
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pending;
  logic [2:0] kind_q;
  logic [23:0] addr_q;
  logic [3:0] delay;
  logic alert;
  logic alert_hold;
  int alert_left;
  // ----------------------------------------
  // Reply generation
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      {pending, kind_q, addr_q, delay, alert, alert_hold} <= '0;
      {reply_valid, reply_decoded, reply_address, reply_alert} <= '0;
      {range_reply_valid, range_measured} <= '0;
      alert_left <= 0;
    end
    else
    begin
      reply_valid <= 1'b0;
      range_reply_valid <= 1'b0;
      // Released lines toggle so a stale copy never looks like a reply
      if (reply_valid || range_reply_valid)
        {reply_decoded, reply_address, reply_alert, range_measured} <=
          ~{reply_decoded, reply_address, reply_alert, range_measured};
      // Short fourth pulse Mode A/C and broadcasts draw no Mode S reply
      // Broadcasts lack the collision-avoidance header: data-link only
      if (interrog.valid && !pending && interrog.kind != MSA_INT_BCAST && interrog.kind != MSA_INT_MODEAC)
      begin
        pending <= 1'b1;
        kind_q <= interrog.kind;
        addr_q <= interrog.address;
        delay <= slow ? 4'hC : 4'h2;
      end
      else if (pending && delay != 4'h0)
        delay <= delay - 4'h1;
      else if (pending)
      begin
        pending <= 1'b0;
        reply_valid <= (kind_q != MSA_INT_RANGE);
        range_reply_valid <= (kind_q == MSA_INT_RANGE);
        reply_decoded <= !garble;
        reply_address <= addr_q;
        reply_alert <= alert;
        range_measured <= RANGE_VALUE;
      end
      if (code_change)
      begin
        alert <= 1'b1;
        alert_hold <= emergency;
        alert_left <= ALERT_CYCLES;
      end
      else if (alert && !alert_hold)
      begin
        alert <= (alert_left > 1);
        alert_left <= alert_left - 1;
      end
    end
endmodule // msa_transponder_model

// ---- msa_scheduler_bench.sv ----
// Purpose: Self-checking bench for the acquisition scheduler
// Assumes: Register offsets and status bits as the designer placed them
// Notes: Waits are bounded; a watchdog ends a hang
module msa_scheduler_bench
  import msa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF, tl = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic reply_valid, reply_decoded, reply_alert, range_reply_valid, handoff_valid, garble_flag;
  logic [23:0] reply_address;
  logic [13:0] range_measured;
  logic [2:0] range_sector;
  logic garble = 1'b0, slow = 1'b0, code_change = 1'b0, emergency = 1'b0;
  msa_interrog_s interrog;
  msa_target_s handoff, handoff_q;
  int err_total = 0, checks_done = 0;
  int ev [10];
  logic [23:0] kaddr [8];
  logic [3:0] kslot [8];
  always #2.5 clk = ~clk;
  msa_scheduler #(.TRACK_DEPTH(16)) msa_scheduler_i (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .modeac_period_start(tl[0]), .rollcall_slot(tl[1]), .scan_start(tl[2]), .beam_step(tl[3]),
    .reply_valid, .reply_decoded, .reply_address, .reply_alert, .range_reply_valid, .range_measured,
    .interrog, .range_sector, .handoff, .handoff_valid, .garble_flag);
  msa_transponder_model #(.ALERT_CYCLES(300)) msa_transponder_model_i (.clk, .rst_n, .interrog, .garble, .slow,
    .code_change, .emergency, .reply_valid, .reply_decoded, .reply_address, .reply_alert, .range_reply_valid,
    .range_measured);
  // ----------------------------------------
  // Output monitor
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (interrog.valid === 1'b1)
    begin
      ev[interrog.kind]++;
      kaddr[interrog.kind] = interrog.address;
      kslot[interrog.kind] = interrog.slot;
      if (interrog.kind === MSA_INT_MODEAC)
        chk({31'h0, interrog.fourth_pulse_short}, 32'h1, "fourth pulse");
      if (interrog.kind === MSA_INT_ALT)
        chk({31'h0, interrog.altitude_req}, 32'h1, "altitude request");
    end
    if (garble_flag === 1'b1)
      ev[8]++;
    if (handoff_valid === 1'b1)
      handoff_q = handoff;
    if (handoff_valid === 1'b1)
      ev[9]++;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_min(input int got, input int lo, input string what);
    chk({31'h0, got >= lo}, 32'h1, what);
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
        break;
    end
    s_axi_bready <= 1'b0;
    chk({29'h0, s_axi_bvalid, s_axi_bresp}, {29'h0, 1'b1, er}, "write response");
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
        break;
    end
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
    chk({29'h0, s_axi_rvalid, s_axi_rresp}, {29'h0, 1'b1, er}, "read response");
  endtask
  // Timeline strobe: 0 Mode A/C period, 1 roll-call slot, 2 scan, 3 beam
  task automatic pulse(input logic [3:0] p, input int times);
    repeat (times)
    begin
      @(posedge clk);
      tl <= p;
      @(posedge clk);
      tl <= 4'h0;
      repeat (30) @(posedge clk);
    end
  endtask
  task automatic wait_ev(input int k, input int base);
    for (int n = 0; n < 400 && ev[k] <= base; n++) @(posedge clk);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    logic [31:0] rd;
    int b;
    logic [3:0] s0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    axi_rd(MSA_OFF_CTRL, rd, MSA_RESP_OKAY);
    chk(rd, MSA_CTRL_RST, "control reset value");
    axi_rd(MSA_OFF_BCAST, rd, MSA_RESP_OKAY);
    chk(rd, MSA_BCAST_RST, "broadcast reset value");
    axi_rd(MSA_OFF_CMD, rd, MSA_RESP_SLVERR);
    axi_rd(8'h20, rd, MSA_RESP_SLVERR);
    axi_wr(8'h20, 32'h0, MSA_RESP_SLVERR);
    axi_wr(MSA_OFF_CTRL, 32'h0000_2125, MSA_RESP_OKAY);
    axi_wr(MSA_OFF_CAND_POS, 32'h0064_0064, MSA_RESP_OKAY);
    axi_rd(MSA_OFF_STATUS, rd, MSA_RESP_OKAY);
    chk({31'h0, rd[13]}, 32'h1, "squitter bearing agrees");
    axi_wr(MSA_OFF_CAND_POS, 32'h00C8_0064, MSA_RESP_OKAY);
    axi_rd(MSA_OFF_STATUS, rd, MSA_RESP_OKAY);
    chk({31'h0, rd[13]}, 32'h0, "squitter bearing disagrees");
    axi_wr(MSA_OFF_CAND_ADDR, 32'h00A5_C3E1, MSA_RESP_OKAY);
    axi_wr(MSA_OFF_CMD, 32'h1, MSA_RESP_OKAY);
    garble <= 1'b1;
    b = ev[MSA_INT_ACQ];
    pulse(4'h2, 3);
    chk(ev[MSA_INT_ACQ] - b, 0, "no acquisition in roll-call");
    pulse(4'h1, 1);
    wait_ev(MSA_INT_ACQ, b);
    chk(ev[MSA_INT_ACQ] - b, 1, "acquisition at period start");
    chk({8'h0, kaddr[MSA_INT_ACQ]}, 32'h00A5_C3E1, "acquisition address");
    s0 = kslot[MSA_INT_ACQ];
    wait_ev(8, 0);
    chk_min(ev[8], 1, "garble flag");
    garble <= 1'b0;
    slow <= 1'b1;
    b = ev[MSA_INT_ACQ];
    pulse(4'h1, 1);
    wait_ev(MSA_INT_ACQ, b);
    chk({31'h0, kslot[MSA_INT_ACQ] !== s0}, 32'h1, "retry at new slot");
    wait_ev(9, 0);
    chk({8'h0, handoff_q.address}, 32'h00A5_C3E1, "handoff address");
    chk({6'h0, range_sector, handoff_q.bearing, handoff_q.range}, 32'h0119_0ABC, "sector, bearing, range");
    axi_wr(MSA_OFF_CMD, 32'h1, MSA_RESP_OKAY);
    axi_rd(MSA_OFF_STATUS, rd, MSA_RESP_OKAY);
    chk({30'h0, rd[5:4]}, 32'h0, "tracked address stays idle");
    b = ev[MSA_INT_IDENT];
    pulse(4'h2, 2);
    chk_min(ev[MSA_INT_IDENT] - b, 1, "identity on acquisition");
    b = ev[MSA_INT_ALT];
    pulse(4'h2, 4);
    chk_min(ev[MSA_INT_ALT] - b, 1, "routine roll-call");
    chk({8'h0, kaddr[MSA_INT_ALT]}, 32'h00A5_C3E1, "roll-call address");
    slow <= 1'b0;
    code_change <= 1'b1;
    @(posedge clk);
    code_change <= 1'b0;
    pulse(4'h2, 1);
    b = ev[MSA_INT_IDENT];
    pulse(4'h2, 2);
    chk_min(ev[MSA_INT_IDENT] - b, 1, "identity during alert");
    repeat (300) @(posedge clk);
    pulse(4'h2, 1);
    b = ev[MSA_INT_IDENT];
    pulse(4'h2, 1);
    chk_min(ev[MSA_INT_IDENT] - b, 1, "identity after alert clears");
    pulse(4'h4, 3);
    b = ev[MSA_INT_ALT];
    pulse(4'h2, 2);
    chk_min(ev[MSA_INT_ALT] - b, 1, "identity requests end");
    axi_wr(MSA_OFF_CTRL, 32'h0000_210D, MSA_RESP_OKAY);
    axi_wr(MSA_OFF_CMD, 32'h4, MSA_RESP_OKAY);
    b = ev[MSA_INT_SHORT];
    pulse(4'h2, 2);
    chk_min(ev[MSA_INT_SHORT] - b, 1, "short test interrogation");
    b = ev[MSA_INT_MODEAC];
    pulse(4'h1, 1);
    chk(ev[MSA_INT_MODEAC] - b, 1, "Mode A/C in period");
    axi_wr(MSA_OFF_CTRL, 32'h0000_2105, MSA_RESP_OKAY);
    axi_wr(MSA_OFF_BCAST, 32'h8000_0003, MSA_RESP_OKAY);
    b = ev[MSA_INT_BCAST];
    pulse(4'h8, 1);
    pulse(4'h2, 6);
    chk_min(ev[MSA_INT_BCAST] - b, 3, "broadcasts per beam");
    tally_and_finish();
  end
  initial
  begin
    #100us;
    err_total++;
    tally_and_finish();
  end
endmodule // msa_scheduler_bench
